// *** hw/hbridge_pkg.sv ***
package hbridge_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] CONFIG_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;

	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int CTRL_RUN_BIT     = 1;
	localparam int CFG_DIR_BIT      = 0;
	localparam int CFG_LOWSIDE_BIT  = 1;
	localparam int CFG_D1_BIT       = 2;
	localparam int CFG_D2_BIT       = 3;
	localparam int CFG_DUTY_LSB     = 8;
	localparam int CFG_FREQ_LSB     = 16;

	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] CONFIG_RESET = 32'h01F4_0C0C;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ         = 50_000_000;
	localparam int FREQ_MAX_FAST  = 20_000;
	localparam int FREQ_MAX_SLOW  = 10_000;
	localparam int FREQ_MIN_HZ    = 1;
	localparam int DUTY_MAX_PCT   = 100;

	typedef struct packed {
		logic       reverse;
		logic       low_side;
		logic       d1_enable;
		logic       d2_enable;
		logic [6:0] duty;
		logic [15:0] freq;
	} drive_cfg_s;

endpackage : hbridge_pkg

// *** hw/pwm_core.sv ***
`timescale 1ns/1ns
module pwm_core
	import hbridge_pkg::*;
#(
	parameter int CLK_FREQ = CLK_HZ
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        run,
	input  wire logic [15:0] freq_hz,
	input  wire logic [6:0]  duty_pct,
	output logic             pwm_out
);
	// Percent tick: period split into 100 steps of one percent each.
	localparam int DIVW = 32;

	if (CLK_FREQ < DUTY_MAX_PCT) begin : g_clk_check
		$error("CLK_FREQ too low for percent steps");
	end

	logic [DIVW-1:0] tick_cnt_reg;
	logic [6:0]      step_reg;
	logic            pwm_reg;
	wire  [DIVW-1:0] tick_len = DIVW'(CLK_FREQ / (int'(freq_hz) * DUTY_MAX_PCT));
	wire             tick_en  = (tick_cnt_reg + 1'b1 >= tick_len);
	wire             step_end = (step_reg == 7'(DUTY_MAX_PCT - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
			step_reg     <= '0;
			pwm_reg      <= 1'b0;
		end else if (!run) begin
			tick_cnt_reg <= '0;
			step_reg     <= '0;
			pwm_reg      <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_en ? '0 : tick_cnt_reg + 1'b1;
			if (tick_en)
				step_reg <= step_end ? 7'h00 : step_reg + 7'h01;
			pwm_reg <= (step_reg < duty_pct);
		end
	end

	assign pwm_out = pwm_reg;

endmodule : pwm_core

// *** hw/hbridge_direction_pwm_drive.sv ***
// Summary of operation
// - forward high-side: A high, B PWM
// - reverse high-side: A low, B PWM
// - forward low-side: A PWM, B low
// - reverse low-side: A low, B PWM
// - fast variant frequency capped at 20 kHz
// - slow variant frequency capped at 10 kHz
// - settings frozen while running, change after stop
// - status shows target enable; drive needs it
// - both disable controls driven to enabling levels; here only while driving, each per its d1_enable/d2_enable bit
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module hbridge_direction_pwm_drive
	import hbridge_pkg::*;
#(
	parameter bit FAST_VARIANT = 1'b1,
	parameter int CLK_FREQ     = CLK_HZ
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             bridge_input_a,
	output logic             bridge_input_b,
	output logic             active_high_disable_ctl,
	output logic             active_low_disable_ctl
);

	// A slower clock would leave the top frequency with steps shorter than one cycle.
	if (CLK_FREQ < FREQ_MAX_FAST * DUTY_MAX_PCT) begin : g_clk_check
		$error("CLK_FREQ too low for percent PWM resolution");
	end

	localparam logic [15:0] FREQ_MAX = FAST_VARIANT ? 16'(FREQ_MAX_FAST) : 16'(FREQ_MAX_SLOW);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire        acc      = psel && penable;
	wire        wr       = acc && pwrite;
	wire        hit_ctrl = (paddr == CTRL_OFS);
	wire        hit_cfg  = (paddr == CONFIG_OFS);
	wire        hit_stat = (paddr == STATUS_OFS);
	wire        mapped   = hit_ctrl || hit_cfg || hit_stat;

	logic        enable_reg;
	logic        run_reg;
	drive_cfg_s  cfg_reg;
	logic        a_reg;
	logic        b_reg;
	logic        d1_reg;
	logic        d2n_reg;
	logic        pwm;

	wire [15:0] wfreq    = pwdata[CFG_FREQ_LSB +: 16];
	wire [6:0]  wduty    = pwdata[CFG_DUTY_LSB +: 7];
	wire [15:0] freq_lim = (wfreq > FREQ_MAX) ? FREQ_MAX :
	                       (wfreq < 16'(FREQ_MIN_HZ)) ? 16'(FREQ_MIN_HZ) : wfreq;
	wire [6:0]  duty_lim = (wduty > 7'(DUTY_MAX_PCT)) ? 7'(DUTY_MAX_PCT) : wduty;
	wire        cfg_lock = run_reg;
	wire        cfg_bad  = wr && hit_cfg && cfg_lock;
	wire        driving  = run_reg && enable_reg;

	wire [31:0] ctrl_rd = {30'h0, run_reg, enable_reg};
	wire [31:0] cfg_rd  = {cfg_reg.freq, 1'b0, cfg_reg.duty, 4'h0, cfg_reg.d2_enable,
	                       cfg_reg.d1_enable, cfg_reg.low_side, cfg_reg.reverse};
	wire [31:0] stat_rd = {28'h0, b_reg, a_reg, driving, enable_reg};

	assign pready  = 1'b1;
	assign pslverr = acc && (!mapped || cfg_bad);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= CTRL_RESET[CTRL_ENABLE_BIT];
			run_reg    <= CTRL_RESET[CTRL_RUN_BIT];
			cfg_reg    <= '{reverse:   CONFIG_RESET[CFG_DIR_BIT],
			                low_side:  CONFIG_RESET[CFG_LOWSIDE_BIT],
			                d1_enable: CONFIG_RESET[CFG_D1_BIT],
			                d2_enable: CONFIG_RESET[CFG_D2_BIT],
			                duty:      CONFIG_RESET[CFG_DUTY_LSB +: 7],
			                freq:      CONFIG_RESET[CFG_FREQ_LSB +: 16]};
			prdata     <= '0;
		end else begin
			if (wr && hit_ctrl) begin
				enable_reg <= pwdata[CTRL_ENABLE_BIT];
				run_reg    <= pwdata[CTRL_RUN_BIT];
			end
			if (wr && hit_cfg && !cfg_lock)
				cfg_reg <= '{reverse: pwdata[CFG_DIR_BIT], low_side: pwdata[CFG_LOWSIDE_BIT],
				             d1_enable: pwdata[CFG_D1_BIT], d2_enable: pwdata[CFG_D2_BIT],
				             duty: duty_lim, freq: freq_lim};
			if (psel && !penable && !pwrite)
				prdata <= hit_ctrl ? ctrl_rd : hit_cfg ? cfg_rd : hit_stat ? stat_rd : 32'h0;
		end
	end

	pwm_core #(
		.CLK_FREQ (CLK_FREQ)
	) u_pwm (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (driving),
		.freq_hz  (cfg_reg.freq),
		.duty_pct (cfg_reg.duty),
		.pwm_out  (pwm)
	);

	// ----------------------------------------------------------------
	// Bridge outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_reg   <= 1'b0;
			b_reg   <= 1'b0;
			d1_reg  <= 1'b1;
			d2n_reg <= 1'b0;
		end else if (!driving) begin
			a_reg   <= 1'b0;
			b_reg   <= 1'b0;
			d1_reg  <= 1'b1;
			d2n_reg <= 1'b0;
		end else begin
			d1_reg  <= !cfg_reg.d1_enable;
			d2n_reg <= cfg_reg.d2_enable;
			case ({cfg_reg.low_side, cfg_reg.reverse})
				2'b00: begin
					a_reg <= 1'b1;
					b_reg <= pwm;
				end
				2'b01: begin
					a_reg <= 1'b0;
					b_reg <= pwm;
				end
				2'b10: begin
					a_reg <= pwm;
					b_reg <= 1'b0;
				end
				default: begin
					a_reg <= 1'b0;
					b_reg <= pwm;
				end
			endcase
		end
	end

	assign bridge_input_a          = a_reg;
	assign bridge_input_b          = b_reg;
	assign active_high_disable_ctl = d1_reg;
	assign active_low_disable_ctl  = d2n_reg;

endmodule : hbridge_direction_pwm_drive

// *** dv/hb_chk_assertions.sv ***
`timescale 1ns/1ns
module hb_chk
	import hbridge_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        bridge_input_a,
	input wire logic        bridge_input_b,
	input wire logic        active_high_disable_ctl,
	input wire logic        active_low_disable_ctl
);
	logic        run_r;
	logic        en_r;
	logic [14:0] c;
	wire         wr  = psel & penable & pwrite;
	wire         drv = run_r & en_r;
	wire         hs  = drv & !c[1];
	// A refused write must not move the shadow, or every mode check drifts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run_r, en_r} <= 2'h0;
			c <= CONFIG_RESET[14:0];
		end else if (wr && paddr == CTRL_OFS) begin
			{run_r, en_r} <= pwdata[1:0];
		end else if (wr && paddr == CONFIG_OFS && !run_r) begin
			c <= pwdata[14:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_fwd_high: assert property ((hs && !c[0]) [*4] |-> bridge_input_a)
		else $error("a low in forward high-side");
	a_reverse_a: assert property ((drv && c[0]) [*4] |-> !bridge_input_a)
		else $error("a high in reverse");
	a_fwd_low: assert property ((drv && c[1] && !c[0]) [*4] |-> !bridge_input_b)
		else $error("b high in forward low-side");
	a_idle_low: assert property ((!drv) [*4] |-> !bridge_input_a && !bridge_input_b)
		else $error("bridge driven while idle");
	a_enable_ctl: assert property ((drv && c[2] && c[3]) [*4] |->
		!active_high_disable_ctl && active_low_disable_ctl)
		else $error("disable controls not enabling");
	a_cfg_lock: assert property (wr && paddr == CONFIG_OFS && run_r |-> pslverr)
		else $error("config write while running not refused");
	a_duty_full: assert property ((hs && c[14:8] > 7'h63) [*5] |-> bridge_input_b)
		else $error("full duty not high");
	a_duty_zero: assert property ((hs && c[14:8] == 7'h00) [*5] |-> !bridge_input_b)
		else $error("zero duty not low");
endmodule : hb_chk
bind hbridge_direction_pwm_drive hb_chk i_hb_chk (
	.pclk                    (pclk),
	.presetn                 (presetn),
	.psel                    (psel),
	.penable                 (penable),
	.pwrite                  (pwrite),
	.paddr                   (paddr),
	.pwdata                  (pwdata),
	.pslverr                 (pslverr),
	.bridge_input_a          (bridge_input_a),
	.bridge_input_b          (bridge_input_b),
	.active_high_disable_ctl (active_high_disable_ctl),
	.active_low_disable_ctl  (active_low_disable_ctl)
);

// *** dv/hb_bridge_model.sv ***
`timescale 1ns/1ns
module hb_bridge_model (
	input  wire logic       bridge_input_a,
	input  wire logic       bridge_input_b,
	input  wire logic       active_high_disable_ctl,
	input  wire logic       active_low_disable_ctl,
	output logic      [1:0] mot_out
);
	logic flip = 1'b0;
	wire  on   = !active_high_disable_ctl && active_low_disable_ctl;
	// Disabled outputs float; a moving pattern keeps a stale level from matching.
	always #10 flip = !flip;
	assign mot_out = on ? {bridge_input_a, bridge_input_b} : {flip, !flip};
endmodule : hb_bridge_model

// *** dv/tb_hbridge_direction_pwm_drive.sv ***
`timescale 1ns/1ns
module tb_hbridge_direction_pwm_drive
	import hbridge_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        bridge_input_a, bridge_input_b, ea, eb, p;
	logic        active_high_disable_ctl, active_low_disable_ctl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, prdata_slow;
	logic [1:0]  mot_out;
	logic [6:0]  d;
	logic [32:0] q[$];
	int          num_errors, check_count, n;
	hbridge_direction_pwm_drive #(.CLK_FREQ(2_000_000)) i_hbridge_direction_pwm_drive (.*);
	hb_bridge_model i_hb_bridge_model (.*);
	// The slow variant shares the bus so its frequency cap can be read back.
	hbridge_direction_pwm_drive #(.FAST_VARIANT(1'b0), .CLK_FREQ(2_000_000))
		i_hbridge_direction_pwm_drive_slow (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_slow), .pready(), .pslverr(), .bridge_input_a(),
		.bridge_input_b(), .active_high_disable_ctl(), .active_low_disable_ctl());
	task chk(string s, logic [32:0] e, logic [32:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task xfer(logic w, logic [11:0] a, logic [31:0] wd, logic [32:0] e);
		q.push_back(e);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask : xfer
	task finish_test;
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	always @(posedge pclk) begin
		if (psel && penable && pready)
			chk("apb", q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
	end
	initial begin
		pclk = 1'b0;
		forever #10 pclk = !pclk;
	end
	initial begin
		#400000;
		num_errors++;
		finish_test;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'hC2C3));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(0, CTRL_OFS, 0, {1'b0, CTRL_RESET});
		xfer(0, CONFIG_OFS, 0, {1'b0, CONFIG_RESET});
		xfer(0, 12'h00C, 0, {1'b1, 32'h0});
		xfer(1, CTRL_OFS, 2, 0);
		xfer(0, STATUS_OFS, 0, 0);
		for (int m = 0; m < 8; m++) begin
			p = m[2];
			ea = m[1] ? (m[0] ? 1'b0 : p) : !m[0];
			eb = (m[1] && !m[0]) ? 1'b0 : p;
			xfer(1, CTRL_OFS, 1, 0);
			xfer(1, CONFIG_OFS, {16'h01F4, 1'b0, p ? 7'h64 : 7'h00, 6'h03, m[1:0]}, 0);
			xfer(1, CTRL_OFS, 3, 0);
			repeat (4) @(posedge pclk);
			xfer(0, STATUS_OFS, 0, {29'h0, eb, ea, 2'h3});
			@(negedge pclk);
			chk("mot", {31'h0, ea, eb}, mot_out);
			@(posedge pclk);
		end
		xfer(1, CONFIG_OFS, 0, {1'b1, 32'h0});
		xfer(0, CONFIG_OFS, 0, {1'b0, 32'h01F4_640F});
		d = 7'($urandom_range(99, 1));
		xfer(1, CTRL_OFS, 1, 0);
		xfer(1, CONFIG_OFS, {16'hFFFF, 1'b0, d, 8'h0C}, 0);
		xfer(0, CONFIG_OFS, 0, {1'b0, 16'(FREQ_MAX_FAST), 1'b0, d, 8'h0C});
		chk("slow freq", 33'(FREQ_MAX_SLOW), {17'h0, prdata_slow[31:16]});
		xfer(1, CTRL_OFS, 3, 0);
		repeat (200) @(posedge pclk);
		n = 0;
		repeat (100) begin
			@(negedge pclk);
			n += bridge_input_b;
		end
		// A capped 20 kHz gives one cycle per step, so 100 cycles hold d highs.
		chk("duty", {26'h0, d}, 33'(n));
		@(posedge pclk);
		xfer(1, CTRL_OFS, 0, 0);
		repeat (5) @(negedge pclk);
		chk("idle", 33'h2, {bridge_input_a, bridge_input_b,
			active_high_disable_ctl, active_low_disable_ctl});
		@(posedge pclk);
		xfer(1, CTRL_OFS, 1, 0);
		xfer(1, CONFIG_OFS, 32'h01F4_0000, 0);
		xfer(1, CTRL_OFS, 3, 0);
		repeat (4) @(negedge pclk);
		chk("off ctl", 33'hA, {bridge_input_a, bridge_input_b,
			active_high_disable_ctl, active_low_disable_ctl});
		finish_test;
	end
endmodule : tb_hbridge_direction_pwm_drive
